// [rdc_consts.svh]
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH

// register offsets on the local register port
`define RDC_OFS_MISC          8'h09
`define RDC_OFS_DSLEW         8'h0A
`define RDC_OFS_CSLEW_TERM    8'h0B
`define RDC_OFS_SWING         8'h0C
`define RDC_OFS_RXEQ          8'h0D
`define RDC_OFS_CHAN_RATE     8'h22
`define RDC_OFS_LANE_RATE     8'h30

// reset values
`define RDC_RST_MISC          8'h12
`define RDC_RST_DSLEW         8'h03
`define RDC_RST_CSLEW_TERM    8'h50
`define RDC_RST_SWING         8'h00
`define RDC_RST_RXEQ          8'h00
`define RDC_RST_CHAN_RATE     8'h00
`define RDC_RST_LANE_RATE     8'h3C

// writable bit masks, reserved bits read zero
`define RDC_MSK_DSLEW         8'h43
`define RDC_MSK_CSLEW_TERM    8'hDF

// misc control field positions
`define RDC_B_SWAP            7
`define RDC_B_INDEP           6
`define RDC_B_ALT             5
`define RDC_B_SIGDET          4
`define RDC_B_PDEN            3
`define RDC_B_HPD_NOAUTO      2

// clock slew / termination field positions
`define RDC_B_FLAG            1
`define RDC_B_OVR             0

// values forced on entry to alternate lane mode
`define RDC_ALT_SWING         8'h80
`define RDC_ALT_RATE          2'h2
`define RDC_ALL_LANES         4'hF

// snoop target
`define RDC_SNOOP_WR_ADDR     8'hA8
`define RDC_SNOOP_RD_ADDR     8'hA9
`define RDC_SNOOP_OFS         8'h20

// stretch time: a quarter bit at each channel rate
`define RDC_CLK_NS            50
`define RDC_QTR_100K_NS       2500
`define RDC_QTR_400K_NS       625

`endif

// [rdc_pkg.sv]
package rdc_pkg;

	// source termination codes
	typedef enum logic [1:0] {
		RDC_TERM_150_300 = 2'h0,
		RDC_TERM_NONE    = 2'h1,
		RDC_TERM_AUTO    = 2'h2,
		RDC_TERM_75_150  = 2'h3
	} rdc_term_t;

	// register write request from the local port
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rdc_reg_req_t;

	// applied driver configuration
	typedef struct packed {
		rdc_term_t  term_sel;
		logic [1:0] clk_slew;
		logic [1:0] data_slew;
		logic [2:0] data_swing_level;
		logic [2:0] clk_swing_level;
		logic [1:0] data_preemph;
		logic [1:0] clk_preemph;
		logic [3:0] rx_eq;
		logic [3:0] lane_en;
		logic [1:0] lane_rate;
		logic       alternate_lane_mode;
		logic       lane_swap;
		logic       signal_detect_enable;
		logic       power_down;
		logic       clock_ratio_flag;
	} rdc_drv_cfg_t;

	// open-drain pins of the display data channel
	typedef struct packed {
		logic src_clk_out;
		logic src_clk_oe;
		logic src_dat_out;
		logic src_dat_oe;
		logic snk_clk_out;
		logic snk_clk_oe;
		logic snk_dat_out;
		logic snk_dat_oe;
	} rdc_ddc_pins_t;

endpackage

// [rdc_snoop.sv]
`timescale 1ns/10ps
`include "rdc_consts.svh"

module rdc_snoop (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// synchronised source-side lines
	input  wire logic scl,
	input  wire logic sda,
	// flag update
	output logic      upd,
	output logic      upd_val
);

	typedef struct packed {
		logic [3:0] bitcnt;
		logic [1:0] byte_idx;
		logic [7:0] shreg;
		logic       is_wr;
		logic       is_rd;
		logic [7:0] ptr;
		logic       scl_prev;
		logic       sda_prev;
		logic       upd;
		logic       upd_val;
	} rdc_snoop_st_t;

	rdc_snoop_st_t st;
	rdc_snoop_st_t next_st;

	// byte tracking on the channel
	always_comb begin
		next_st          = st;
		next_st.scl_prev = scl;
		next_st.sda_prev = sda;
		next_st.upd      = 1'b0;
		if (scl && st.scl_prev && st.sda_prev && !sda) begin
			next_st.bitcnt   = 4'h0;
			next_st.byte_idx = 2'h0;
		end else if (scl && st.scl_prev && !st.sda_prev && sda) begin
			next_st.is_wr = 1'b0;
			next_st.is_rd = 1'b0;
		end else if (scl && !st.scl_prev) begin
			if (st.bitcnt != 4'h8) begin
				next_st.shreg  = {st.shreg[6:0], sda};
				next_st.bitcnt = st.bitcnt + 4'h1;
			end else begin
				next_st.bitcnt = 4'h0;
				if (st.byte_idx != 2'h2)
					next_st.byte_idx = st.byte_idx + 2'h1;
				if (st.byte_idx == 2'h0) begin
					next_st.is_wr = !sda && st.shreg == `RDC_SNOOP_WR_ADDR;
					next_st.is_rd = !sda && st.shreg == `RDC_SNOOP_RD_ADDR;
				end else if (st.is_wr && st.byte_idx == 2'h1) begin
					next_st.ptr = st.shreg;
				end else if (st.is_wr && !sda) begin
					next_st.upd     = st.ptr == `RDC_SNOOP_OFS;
					next_st.upd_val = st.shreg[1];
					next_st.ptr     = st.ptr + 8'h01;
				end else if (st.is_rd) begin
					next_st.upd     = st.ptr == `RDC_SNOOP_OFS && st.shreg[1];
					next_st.upd_val = 1'b1;
					next_st.ptr     = st.ptr + 8'h01;
				end
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.scl_prev <= 1'b1;
			st.sda_prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign upd     = st.upd;
	assign upd_val = st.upd_val;

endmodule

// [rdc_top.sv]
// Notes on behaviour
// - code 10 auto, 11/strap high 75-150
// - code 00/low 150-300, 01/float none
// - swing levels from swing register bits 7:2
// - clock slew from strap or register
// - data slew register only, reset fastest
// - clock lane pre-emphasis only in alternate
// - pre-emphasis default 0 dB, strap 0/3.5
// - register pre-emphasis 0, 3.5, 6 dB
// - alternate mode bit, straps then ignored
// - alternate mode ignores swap, signal detect
// - alternate entry forces lanes, swing, global
// - alternate global swing from bits 7:5
// - global receive equalizer from bits 6:3
// - lane register gives rate, enables only in alternate
// - snoop target offset bit into flag
// - flag one means ratio 1/40, default 0
// - flag cleared on hot-plug power-down
// - override bit selects software-written flag
// - relay start, data, responses between sides
// - channel rate 100k default, 400k option
// - stretch source clock while relaying
`timescale 1ns/10ps
`include "rdc_consts.svh"

module rdc_top (
	// clock and reset (enable pin)
	input  wire logic                mclk,
	input  wire logic                rstn,
	// local register port
	input  wire rdc_pkg::rdc_reg_req_t reg_req,
	input  wire logic [7:0]          reg_rd_addr,
	output logic [7:0]               reg_rdata,
	// straps and hot-plug pins
	input  wire logic                local_port_en,
	input  wire logic [1:0]          term_strap,
	input  wire logic [1:0]          clk_slew_strap,
	input  wire logic                preemph_strap_pin,
	input  wire logic                sink_hotplug_in,
	// display data channel pin inputs
	input  wire logic                source_side_clock_in,
	input  wire logic                source_side_data_in,
	input  wire logic                sink_side_clock_in,
	input  wire logic                sink_side_data_in,
	// display data channel pin drives
	output rdc_pkg::rdc_ddc_pins_t   ddc_pins,
	// applied driver configuration
	output rdc_pkg::rdc_drv_cfg_t    drv_cfg
);

	localparam int PIN_W = 11;
	localparam logic [7:0] QTR_STD =
		8'(`RDC_QTR_100K_NS / `RDC_CLK_NS);
	localparam logic [7:0] QTR_FAST =
		8'(`RDC_QTR_400K_NS / `RDC_CLK_NS);

	typedef struct packed {
		logic [PIN_W-1:0]       pin_s1;
		logic [PIN_W-1:0]       pin_s2;
		logic [7:0]             misc;
		logic [7:0]             dslew;
		logic [7:0]             cslew_term;
		logic [7:0]             swing;
		logic [7:0]             rxeq;
		logic [7:0]             chan_rate;
		logic [7:0]             lane_rate;
		logic                   flag;
		logic                   busy;
		logic                   scl_prev;
		logic                   sda_prev;
		logic [7:0]             stretch_cnt;
		logic [1:0]             snk_guard;
		logic [1:0]             src_guard;
		logic [7:0]             rdata;
		rdc_pkg::rdc_ddc_pins_t pins;
		rdc_pkg::rdc_drv_cfg_t  cfg;
	} rdc_top_st_t;

	rdc_top_st_t st;
	rdc_top_st_t next_st;

	logic             snoop_upd;
	logic             snoop_val;
	logic [1:0]       s_term;
	logic [1:0]       s_cslew;
	logic             s_pre;
	logic             s_lpen;
	logic             s_hpd;
	logic             s_sscl;
	logic             s_ssda;
	logic             s_kscl;
	logic             s_ksda;

	// synchronised pin view, second stage only
	assign {s_term, s_cslew, s_pre, s_lpen, s_hpd,
		s_sscl, s_ssda, s_kscl, s_ksda} = st.pin_s2;

	// byte snooper on the source side
	rdc_snoop u_snoop (
		.mclk    (mclk),
		.rstn    (rstn),
		.scl     (s_sscl),
		.sda     (s_ssda),
		.upd     (snoop_upd),
		.upd_val (snoop_val)
	);

	// next state of registers, flag, relay and configuration
	always_comb begin
		logic       alt;
		logic       strap_mode;
		logic       ovr;
		logic       hpd_pd;
		logic       start_det;
		logic       stop_det;
		logic       relay_on;
		logic [1:0] term_code;
		logic [7:0] rd;

		next_st        = st;
		alt            = 1'b0;
		strap_mode     = 1'b0;
		ovr            = 1'b0;
		hpd_pd         = 1'b0;
		start_det      = 1'b0;
		stop_det       = 1'b0;
		relay_on       = 1'b0;
		term_code      = 2'h0;
		rd             = 8'h00;

		next_st.pin_s1 = {term_strap, clk_slew_strap, preemph_strap_pin,
			local_port_en, sink_hotplug_in, source_side_clock_in,
			source_side_data_in, sink_side_clock_in, sink_side_data_in};
		next_st.pin_s2 = st.pin_s1;

		// register writes from the local port
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`RDC_OFS_MISC: begin
					next_st.misc = reg_req.wdata;
					if (reg_req.wdata[`RDC_B_ALT] && !st.misc[`RDC_B_ALT]) begin
						next_st.misc[`RDC_B_INDEP] = 1'b0;
						next_st.swing              = `RDC_ALT_SWING;
						next_st.lane_rate = {`RDC_ALT_RATE, `RDC_ALL_LANES,
							2'h0};
					end
				end
				`RDC_OFS_DSLEW:
					next_st.dslew = reg_req.wdata & `RDC_MSK_DSLEW;
				`RDC_OFS_CSLEW_TERM:
					next_st.cslew_term = reg_req.wdata & `RDC_MSK_CSLEW_TERM;
				`RDC_OFS_SWING:
					next_st.swing = reg_req.wdata;
				`RDC_OFS_RXEQ:
					next_st.rxeq = reg_req.wdata;
				`RDC_OFS_CHAN_RATE:
					next_st.chan_rate = reg_req.wdata;
				`RDC_OFS_LANE_RATE:
					next_st.lane_rate = reg_req.wdata;
				default: begin
				end
			endcase
		end

		alt        = st.misc[`RDC_B_ALT];
		strap_mode = !s_lpen && !alt;
		ovr        = st.cslew_term[`RDC_B_OVR];
		hpd_pd     = !s_hpd && !st.misc[`RDC_B_HPD_NOAUTO];

		if (ovr && reg_req.wr && reg_req.addr == `RDC_OFS_CSLEW_TERM)
			next_st.flag = reg_req.wdata[`RDC_B_FLAG];
		else if (hpd_pd && !(snoop_upd && !ovr))
			next_st.flag = 1'b0;
		if (snoop_upd && !ovr)
			next_st.flag = snoop_val;

		// register read data
		unique case (reg_rd_addr)
			`RDC_OFS_MISC:       rd = st.misc;
			`RDC_OFS_DSLEW:      rd = st.dslew;
			`RDC_OFS_CSLEW_TERM: rd = {st.cslew_term[7:2], st.flag,
				st.cslew_term[0]};
			`RDC_OFS_SWING:      rd = st.swing;
			`RDC_OFS_RXEQ:       rd = st.rxeq;
			`RDC_OFS_CHAN_RATE:  rd = st.chan_rate;
			`RDC_OFS_LANE_RATE:  rd = st.lane_rate;
			default:             rd = 8'h00;
		endcase
		next_st.rdata = rd;

		// termination choice
		if (strap_mode) begin
			term_code = s_term;
		end else begin
			term_code = st.cslew_term[4:3];
		end
		if (term_code == 2'h2) begin
			if (!ovr && st.flag)
				next_st.cfg.term_sel = rdc_pkg::RDC_TERM_75_150;
			else
				next_st.cfg.term_sel = rdc_pkg::RDC_TERM_NONE;
		end else begin
			next_st.cfg.term_sel = rdc_pkg::rdc_term_t'(term_code);
		end

		next_st.cfg.clk_slew = strap_mode ? s_cslew : st.cslew_term[7:6];
		next_st.cfg.data_slew = st.dslew[1:0];

		next_st.cfg.data_swing_level = st.swing[7:5];
		next_st.cfg.clk_swing_level  = st.swing[4:2];
		if (alt)
			next_st.cfg.clk_swing_level = st.swing[7:5];

		// strap gives 0 or 3.5 dB
		// register gives 0, 3.5, 6 dB
		next_st.cfg.data_preemph = strap_mode ? {1'b0, s_pre}
			: st.swing[1:0];
		// clock lane only in alternate mode
		next_st.cfg.clk_preemph = alt ? st.swing[1:0] : 2'h0;

		next_st.cfg.rx_eq = st.rxeq[6:3];
		next_st.cfg.lane_en   = alt ? st.lane_rate[5:2] : `RDC_ALL_LANES;
		next_st.cfg.lane_rate = st.lane_rate[7:6];

		next_st.cfg.alternate_lane_mode = alt;
		next_st.cfg.lane_swap = st.misc[`RDC_B_SWAP] && !alt;
		next_st.cfg.signal_detect_enable = st.misc[`RDC_B_SIGDET] && !alt;
		next_st.cfg.power_down = st.misc[`RDC_B_PDEN] || hpd_pd;
		// ratio flag to the driver side
		next_st.cfg.clock_ratio_flag = st.flag;

		// start and stop on the source side
		next_st.scl_prev = s_sscl;
		next_st.sda_prev = s_ssda;
		start_det = s_sscl && st.scl_prev && st.sda_prev && !s_ssda;
		stop_det  = s_sscl && st.scl_prev && !st.sda_prev && s_ssda;
		if (start_det)
			next_st.busy = 1'b1;
		else if (stop_det)
			next_st.busy = 1'b0;
		relay_on = st.busy || start_det;

		// own pull still in the synchroniser: ignore that side a while
		next_st.snk_guard = st.pins.snk_dat_oe ? 2'h3
			: (st.snk_guard != 2'h0 ? st.snk_guard - 2'h1 : 2'h0);
		next_st.src_guard = st.pins.src_dat_oe ? 2'h3
			: (st.src_guard != 2'h0 ? st.src_guard - 2'h1 : 2'h0);
		next_st.pins.snk_clk_oe = relay_on && !s_sscl;
		next_st.pins.snk_dat_oe = relay_on && !s_ssda
			&& !st.pins.src_dat_oe && st.src_guard == 2'h0;
		next_st.pins.src_dat_oe = relay_on && !s_ksda
			&& !st.pins.snk_dat_oe && st.snk_guard == 2'h0;

		// hold source clock low a quarter bit
		if (st.stretch_cnt != 8'h00) begin
			next_st.stretch_cnt = st.stretch_cnt - 8'h01;
		end else if (st.busy && st.scl_prev && !s_sscl
			&& !st.pins.src_clk_oe) begin
			next_st.stretch_cnt = st.chan_rate[0] ? QTR_FAST : QTR_STD;
		end
		next_st.pins.src_clk_oe = next_st.stretch_cnt != 8'h00;
		if (stop_det)
			next_st.stretch_cnt = 8'h00;
		next_st.pins.src_clk_out = 1'b0;
		next_st.pins.src_dat_out = 1'b0;
		next_st.pins.snk_clk_out = 1'b0;
		next_st.pins.snk_dat_out = 1'b0;
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st            <= '0;
			st.pin_s1     <= '1;
			st.pin_s2     <= '1;
			st.scl_prev   <= 1'b1;
			st.sda_prev   <= 1'b1;
			st.misc       <= `RDC_RST_MISC;
			st.dslew      <= `RDC_RST_DSLEW;
			st.cslew_term <= `RDC_RST_CSLEW_TERM;
			st.swing      <= `RDC_RST_SWING;
			st.rxeq       <= `RDC_RST_RXEQ;
			st.chan_rate  <= `RDC_RST_CHAN_RATE;
			st.lane_rate  <= `RDC_RST_LANE_RATE;
			st.cfg.lane_en <= `RDC_ALL_LANES;
		end else begin
			st <= next_st;
		end
	end

	// outputs come straight from the state register
	assign reg_rdata = st.rdata;
	assign ddc_pins  = st.pins;
	assign drv_cfg   = st.cfg;

endmodule

// [rdc_top_props.sv]
`timescale 1ns/10ps
`include "rdc_consts.svh"

module rdc_top_props (
	// clock and reset
	input wire logic                   mclk,
	input wire logic                   rstn,
	// register port
	input wire rdc_pkg::rdc_reg_req_t  reg_req,
	input wire logic [7:0]             reg_rd_addr,
	input wire logic [7:0]             reg_rdata,
	// pins and configuration
	input wire logic                   source_side_clock_in,
	input wire rdc_pkg::rdc_ddc_pins_t ddc_pins,
	input wire rdc_pkg::rdc_drv_cfg_t  drv_cfg
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [7:0] hold_cnt;
	// length of each source clock stretch
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			hold_cnt <= 8'h00;
		else
			hold_cnt <= ddc_pins.src_clk_oe ? hold_cnt + 8'h01 : 8'h00;
	end
	sequence s_alt_wr;
		reg_req.wr && reg_req.addr == `RDC_OFS_MISC &&
		reg_req.wdata[`RDC_B_ALT] && !drv_cfg.alternate_lane_mode;
	endsequence
	sequence s_alt_cfg;
		drv_cfg.alternate_lane_mode && drv_cfg.lane_en == `RDC_ALL_LANES &&
		drv_cfg.lane_rate == `RDC_ALT_RATE &&
		drv_cfg.data_swing_level == 3'h4 && drv_cfg.data_preemph == 2'h0;
	endsequence
	property p_alt_entry;
		s_alt_wr |-> ##2 s_alt_cfg;
	endproperty
	a_alt_entry: assert property (p_alt_entry)
		else $error("alternate entry defaults wrong");
	property p_term_set;
		drv_cfg.term_sel != rdc_pkg::RDC_TERM_AUTO;
	endproperty
	a_term_set: assert property (p_term_set)
		else $error("auto code applied to driver");
	property p_clk_pre;
		!drv_cfg.alternate_lane_mode |-> drv_cfg.clk_preemph == 2'h0;
	endproperty
	a_clk_pre: assert property (p_clk_pre)
		else $error("clock lane pre-emphasis in normal mode");
	property p_alt_swing;
		drv_cfg.alternate_lane_mode |->
			drv_cfg.clk_swing_level == drv_cfg.data_swing_level;
	endproperty
	a_alt_swing: assert property (p_alt_swing)
		else $error("swing differs between lanes");
	property p_alt_ignore;
		drv_cfg.alternate_lane_mode |->
			!drv_cfg.lane_swap && !drv_cfg.signal_detect_enable;
	endproperty
	a_alt_ignore: assert property (p_alt_ignore)
		else $error("swap or detect active in alternate mode");
	property p_dslew;
		reg_req.wr && reg_req.addr == `RDC_OFS_DSLEW |->
			##2 drv_cfg.data_slew == $past(reg_req.wdata[1:0], 2);
	endproperty
	a_dslew: assert property (p_dslew)
		else $error("data slew not taken from write");
	property p_dslew_rsv;
		reg_rd_addr == `RDC_OFS_DSLEW |=>
			(reg_rdata & ~(`RDC_MSK_DSLEW)) == 8'h00;
	endproperty
	a_dslew_rsv: assert property (p_dslew_rsv)
		else $error("reserved bits read non-zero");
	property p_stretch;
		$fell(ddc_pins.src_clk_oe) |-> hold_cnt == 8'h32 || hold_cnt == 8'h0C;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("stretch length wrong");
	property p_relay_clk;
		ddc_pins.snk_clk_oe |-> !$past(source_side_clock_in, 3);
	endproperty
	a_relay_clk: assert property (p_relay_clk)
		else $error("sink clock pulled without source low");
	property p_no_loop;
		!(ddc_pins.snk_dat_oe && ddc_pins.src_dat_oe) &&
		!(ddc_pins.src_clk_out || ddc_pins.src_dat_out ||
		  ddc_pins.snk_clk_out || ddc_pins.snk_dat_out);
	endproperty
	a_no_loop: assert property (p_no_loop)
		else $error("data relayed both ways or pin driven high");
endmodule

// [rdc_sink_model.sv]
`timescale 1ns/10ps

module rdc_sink_model (
	// clock, reset and wire levels
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic scl,
	input  wire logic sda,
	// slow mode holds the clock after each fall
	input  wire logic slow,
	// pulls on the wires
	output logic      sda_pull,
	output logic      scl_pull
);
	logic [3:0] n;
	logic [4:0] hold;
	logic       busy;
	logic       scl_q;
	logic       sda_q;
	assign scl_pull = (hold != 5'h00);
	// bit count, acknowledge and clock hold
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{n, hold, busy, sda_pull} <= '0;
			{scl_q, sda_q} <= 2'h3;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (hold != 5'h00)
				hold <= hold - 5'h01;
			if (scl && scl_q && sda_q != sda) begin
				busy <= !sda;
				n <= 4'h0;
				sda_pull <= 1'b0;
			end else if (busy && scl && !scl_q) begin
				n <= (n == 4'h8) ? 4'h0 : n + 4'h1;
			end else if (busy && !scl && scl_q) begin
				sda_pull <= (n == 4'h8);
				hold <= slow ? 5'h14 : 5'h00;
			end
		end
	end
endmodule

// [rdc_top_test.sv]
`timescale 1ns/10ps
`include "rdc_consts.svh"

module rdc_top_test;
	logic                   mclk;
	logic                   rstn;
	rdc_pkg::rdc_reg_req_t  reg_req;
	logic [7:0]             reg_rd_addr;
	logic [7:0]             reg_rdata;
	logic                   local_port_en;
	logic [1:0]             term_strap;
	logic [1:0]             clk_slew_strap;
	logic                   preemph_strap_pin;
	logic                   sink_hotplug_in;
	logic                   m_scl;
	logic                   m_sda;
	logic                   slow;
	logic                   s_dat;
	logic                   s_clk;
	rdc_pkg::rdc_ddc_pins_t ddc_pins;
	rdc_pkg::rdc_drv_cfg_t  drv_cfg;
	int                     fail_count;
	int                     compares;
	logic [7:0]             v;
	logic [7:0]             b;
	logic [7:0]             r8;
	logic [7:0]             ofs [8] = '{8'h09, 8'h0A, 8'h0B, 8'h0C,
	                                    8'h0D, 8'h22, 8'h30, 8'h40};
	logic [7:0]             rst [8] = '{8'h12, 8'h03, 8'h50, 8'h00,
	                                    8'h00, 8'h00, 8'h3C, 8'h00};
	logic [7:0]             sw [3] = '{8'h80, 8'hC1, 8'h42};
	logic [1:0]             sc [3] = '{2'h0, 2'h1, 2'h3};
	// open-drain wires with pull-ups
	wire logic sc_w = m_scl & ~ddc_pins.src_clk_oe;
	wire logic sd_w = m_sda & ~ddc_pins.src_dat_oe;
	wire logic kc_w = ~ddc_pins.snk_clk_oe & ~s_clk;
	wire logic kd_w = ~ddc_pins.snk_dat_oe & ~s_dat;
	rdc_top dut (.mclk, .rstn, .reg_req, .reg_rd_addr, .reg_rdata,
		.local_port_en, .term_strap, .clk_slew_strap, .preemph_strap_pin,
		.sink_hotplug_in, .source_side_clock_in(sc_w),
		.source_side_data_in(sd_w), .sink_side_clock_in(kc_w),
		.sink_side_data_in(kd_w), .ddc_pins, .drv_cfg);
	rdc_sink_model u_sink (.mclk, .rstn, .scl(kc_w), .sda(kd_w), .slow,
		.sda_pull(s_dat), .scl_pull(s_clk));
	// expected applied termination for a register code
	function automatic logic [7:0] exp_term(input logic [1:0] t);
		return (t == 2'h2) ? 8'h01 : 8'(t);
	endfunction
	task automatic tally_and_finish;
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic gap(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd_addr <= a;
		gap(1);
		d = reg_rdata;
	endtask
	task automatic wait_clk;
		int i;
		for (i = 0; i < 400 && sc_w !== 1'b1; i++)
			@(posedge mclk);
		if (sc_w !== 1'b1) begin
			fail_count++;
			$display("unexpected at %0t: clock held low", $time);
			tally_and_finish;
		end
	endtask
	task automatic dbit(input logic d, output logic r);
		m_sda <= d;
		repeat (10) @(posedge mclk);
		m_scl <= 1'b1;
		@(posedge mclk);
		wait_clk;
		repeat (20) @(posedge mclk);
		r = sd_w;
		repeat (20) @(posedge mclk);
		m_scl <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic dbyte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			dbit(d[i], r);
		dbit(1'b1, r);
		chk(8'(r), 8'h00);
	endtask
	task automatic txn(input logic [7:0] d);
		@(posedge mclk);
		m_sda <= 1'b0;
		repeat (40) @(posedge mclk);
		m_scl <= 1'b0;
		@(posedge mclk);
		dbyte(`RDC_SNOOP_WR_ADDR);
		dbyte(`RDC_SNOOP_OFS);
		dbyte(d);
		m_sda <= 1'b0;
		repeat (10) @(posedge mclk);
		m_scl <= 1'b1;
		@(posedge mclk);
		wait_clk;
		repeat (40) @(posedge mclk);
		m_sda <= 1'b1;
		gap(40);
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// main sequence
	initial begin
		{rstn, reg_req, reg_rd_addr, term_strap, clk_slew_strap} = '0;
		{local_port_en, sink_hotplug_in, m_scl, m_sda, slow} = 5'h1F;
		preemph_strap_pin = 1'b0;
		fail_count = 0;
		compares = 0;
		v = $urandom(32'hCB75BAF9);
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		gap(4);
		for (int i = 0; i < 8; i++) begin
			rd(ofs[i], v);
			chk(v, rst[i]);
		end
		chk(8'(drv_cfg.data_slew), 8'h03);
		chk(8'(drv_cfg.clock_ratio_flag), 8'h00);
		txn(8'h02);
		chk(8'(drv_cfg.clock_ratio_flag), 8'h01);
		chk(8'(drv_cfg.term_sel), 8'h03);
		@(posedge mclk);
		sink_hotplug_in <= 1'b0;
		slow <= 1'b0;
		gap(8);
		chk(8'(drv_cfg.clock_ratio_flag), 8'h00);
		@(posedge mclk);
		sink_hotplug_in <= 1'b1;
		wr(`RDC_OFS_CHAN_RATE, 8'h01);
		wr(`RDC_OFS_CSLEW_TERM, 8'h11);
		wr(`RDC_OFS_CSLEW_TERM, 8'h13);
		txn(8'hFD);
		chk(8'(drv_cfg.clock_ratio_flag), 8'h01);
		chk(8'(drv_cfg.term_sel), 8'h01);
		for (int i = 0; i < 12; i++) begin
			v = $urandom;
			b = {v[7:6], 1'b0, i[1:0], 1'b0, v[1], 1'b1};
			wr(`RDC_OFS_CSLEW_TERM, b);
			wr(`RDC_OFS_DSLEW, v);
			wr(`RDC_OFS_SWING, v);
			wr(`RDC_OFS_RXEQ, v);
			rd(`RDC_OFS_DSLEW, r8);
			chk(r8, v & `RDC_MSK_DSLEW);
			gap(1);
			chk(8'(drv_cfg.term_sel), exp_term(i[1:0]));
			chk(8'(drv_cfg.clk_slew), 8'(b[7:6]));
			chk(8'(drv_cfg.clock_ratio_flag), 8'(b[1]));
			chk(8'(drv_cfg.data_slew), 8'(v[1:0]));
			chk(8'({drv_cfg.data_swing_level, drv_cfg.clk_swing_level}),
				8'(v[7:2]));
			chk(8'(drv_cfg.data_preemph), 8'(v[1:0]));
			chk(8'(drv_cfg.rx_eq), 8'(v[6:3]));
		end
		@(posedge mclk);
		local_port_en <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			v = $urandom;
			@(posedge mclk);
			term_strap <= sc[i];
			clk_slew_strap <= sc[2 - i];
			preemph_strap_pin <= v[0];
			gap(5);
			chk(8'(drv_cfg.term_sel), 8'(sc[i]));
			chk(8'(drv_cfg.clk_slew), 8'(sc[2 - i]));
			chk(8'(drv_cfg.data_preemph), 8'(v[0]));
		end
		wr(`RDC_OFS_MISC, 8'h20);
		gap(2);
		chk(8'(drv_cfg.term_sel), exp_term(b[4:3]));
		chk(8'(drv_cfg.clk_slew), 8'(b[7:6]));
		rd(`RDC_OFS_LANE_RATE, v);
		chk(v, 8'hBC);
		for (int i = 0; i < 3; i++) begin
			wr(`RDC_OFS_SWING, sw[i]);
			gap(2);
			chk(8'(drv_cfg.clk_swing_level), 8'(sw[i][7:5]));
			chk(8'(drv_cfg.clk_preemph), 8'(sw[i][1:0]));
		end
		v = $urandom;
		wr(`RDC_OFS_RXEQ, v);
		wr(`RDC_OFS_MISC, 8'h60);
		wr(`RDC_OFS_LANE_RATE, v);
		gap(2);
		chk(8'(drv_cfg.rx_eq), 8'(v[6:3]));
		chk(8'({drv_cfg.lane_rate, drv_cfg.lane_en}), 8'(v[7:2]));
		tally_and_finish;
	end
endmodule

bind rdc_top rdc_top_props u_props (.mclk, .rstn, .reg_req, .reg_rd_addr,
	.reg_rdata, .source_side_clock_in, .ddc_pins, .drv_cfg);
